/* design/tag_buffer_pkg.sv */
// Shared constants and types for the three-channel event time-tag store.
// Assumes one 50 MHz core clock and a host that issues one command at a time.
//
// Summary of operation
// - Each of three inputs has its own stamp buffer; commands select one channel.
// - Single-entry reads take an index from 1 to 256 inside the selected buffer.
// - Preset empties all three buffers and zeroes all three overflow counters.
// - No stamp is recorded before power-up completes and reference lock is first reached.
// - With 256 stamps held, each further event increments that channel's overflow counter until it saturates at its maximum.
// - Keep-oldest holds the first 256 stamps; the counter counts discarded events.
// - Keep-newest overwrites the oldest entries; the counter counts overwritten stamps.
// - Retention mode survives power cycles; preset forces keep-oldest.
// - The all-channel overflow read returns three counters in channel order 1, 2, 3.
// - The per-channel overflow read returns only the selected channel's counter.
// - The mode query reports keep-oldest or keep-newest.
// - Each channel captures on rising or falling edges, chosen per channel.
// - Capture is suspended while the host reads, clears or accesses the buffers.
// - The reported stored-stamp count per channel lies between 0 and 256.
// - Each stamp holds date, time to the nanosecond, and a time quality figure.
`default_nettype none

package tag_buffer_pkg;

	// ==========================================================================
	// Sizes
	localparam int              CHANNELS   = 3;
	localparam int              DEPTH      = 256;
	localparam int              PTR_W      = 8;
	localparam int              CNT_W      = 9;
	localparam int              OVF_W      = 32;
	localparam logic [CNT_W-1:0] CNT_FULL  = 9'h100;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 9'h000;
	localparam logic [CNT_W-1:0] ENTRY_MIN = 9'h001;
	localparam logic [OVF_W-1:0] OVF_MAX   = 32'hffffffff;
	localparam logic [OVF_W-1:0] OVF_ZERO  = 32'h00000000;
	localparam logic [1:0]       CHAN_MIN  = 2'h1;
	localparam logic [1:0]       CHAN_MAX  = 2'h3;

	// ==========================================================================
	// Types
	typedef enum logic {RETAIN_OLDEST, RETAIN_NEWEST} retain_e;

	typedef enum logic [2:0] {
		CMD_READ_ENTRY,
		CMD_READ_COUNT,
		CMD_READ_OVF_ALL,
		CMD_READ_OVF_ONE,
		CMD_SET_MODE,
		CMD_GET_MODE,
		CMD_CLEAR_CHAN,
		CMD_PRESET
	} cmd_e;

	typedef struct packed {
		logic [11:0] year;
		logic [3:0]  month;
		logic [4:0]  day;
		logic [4:0]  hour;
		logic [5:0]  minute;
		logic [5:0]  second;
		logic [9:0]  milli;
		logic [9:0]  micro;
		logic [9:0]  nano;
		logic [3:0]  time_quality_figure;
	} stamp_s;

	typedef struct packed {
		cmd_e                     op;
		logic [1:0]               tag_channel_select;
		logic [CNT_W-1:0]         entry;
		retain_e                  mode;
	} cmd_s;

	typedef struct packed {
		stamp_s                        stamp;
		logic [CNT_W-1:0]              count;
		logic [CHANNELS-1:0][OVF_W-1:0] ovf;
		retain_e                       mode;
		logic                          err;
	} rsp_s;

endpackage

`default_nettype wire

/* design/tag_edge_detect.sv */
// Edge detector for one time-tag input with selectable polarity.
// Assumes the input is already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none

module tag_edge_detect
(
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic sig_i,
	input  wire logic fall_i,
	output logic      hit_o
);

	logic prev_r;
	logic prev_nxt;
	logic hit_r;
	logic hit_nxt;

	// ==========================================================================
	// Edge selection
	always_comb
	begin
		prev_nxt = sig_i;
		hit_nxt  = fall_i ? (prev_r & ~sig_i) : (~prev_r & sig_i);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			prev_r <= 1'b0;
			hit_r  <= 1'b0;
		end
		else
		begin
			prev_r <= prev_nxt;
			hit_r  <= hit_nxt;
		end
	end

	assign hit_o = hit_r;

endmodule

`default_nettype wire

/* design/event_time_tag_buffer.sv */
// Three-channel event time-tag store with host command port.
// Assumes a host that waits for cmd_ready_o and a time source already in core_clk_i domain.
`timescale 1ns/1ps
`default_nettype none

module event_time_tag_buffer
	import tag_buffer_pkg::*;
(
	input  wire logic                core_clk_i,
	input  wire logic                rst_i,
	input  wire logic [CHANNELS-1:0] event_i,
	input  wire logic [CHANNELS-1:0] edge_fall_i,
	input  wire logic                powerup_done_i,
	input  wire logic                ref_locked_i,
	input  wire stamp_s              time_now_i,
	input  wire retain_e             nv_mode_i,
	input  wire logic                cmd_valid_i,
	input  wire cmd_s                cmd_i,
	output logic                     cmd_ready_o,
	output logic                     rsp_valid_o,
	output rsp_s                     rsp_o,
	output retain_e                  mode_o,
	output logic                     armed_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_DONE} state_e;

	// ==========================================================================
	// Helpers
	function automatic logic chan_ok(input logic [1:0] sel);
		chan_ok = (sel >= CHAN_MIN) && (sel <= CHAN_MAX);
	endfunction

	function automatic logic [1:0] chan_idx(input logic [1:0] sel);
		chan_idx = chan_ok(sel) ? sel - CHAN_MIN : 2'h0;
	endfunction

	// ==========================================================================
	// Edge detection
	logic [CHANNELS-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_edge
			tag_edge_detect u_edge
			(
				.core_clk_i (core_clk_i),
				.rst_i      (rst_i),
				.sig_i      (event_i[g]),
				.fall_i     (edge_fall_i[g]),
				.hit_o      (hit[g])
			);
		end
	endgenerate

	// ==========================================================================
	// Control: arming, mode and command sequencing
	state_e  state_r;
	state_e  state_nxt;
	logic    armed_r;
	logic    armed_nxt;
	logic    mode_load_r;
	logic    mode_load_nxt;
	retain_e mode_r;
	retain_e mode_nxt;
	cmd_s    cmd_r;
	cmd_s    cmd_nxt;
	logic    cmd_take;

	assign cmd_take = cmd_valid_i && (state_r == ST_IDLE);

	// The retention mode is not a reset constant: it is reloaded from the
	// non-volatile copy one cycle after reset so it survives power cycles.
	always_comb
	begin
		state_nxt     = state_r;
		armed_nxt     = armed_r | (powerup_done_i & ref_locked_i);
		mode_load_nxt = 1'b0;
		mode_nxt      = mode_r;
		cmd_nxt       = cmd_r;
		if (mode_load_r)
			mode_nxt = nv_mode_i;
		case (state_r)
			ST_IDLE:
			begin
				if (cmd_take)
				begin
					cmd_nxt   = cmd_i;
					state_nxt = ST_ACCESS;
				end
			end
			ST_ACCESS:
			begin
				if (cmd_r.op == CMD_SET_MODE)
					mode_nxt = cmd_r.mode;
				if (cmd_r.op == CMD_PRESET)
					mode_nxt = RETAIN_OLDEST;
				state_nxt = ST_DONE;
			end
			ST_DONE:
				state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			state_r     <= ST_IDLE;
			armed_r     <= 1'b0;
			mode_load_r <= 1'b1;
			mode_r      <= RETAIN_OLDEST;
			cmd_r       <= '0;
		end
		else
		begin
			state_r     <= state_nxt;
			armed_r     <= armed_nxt;
			mode_load_r <= mode_load_nxt;
			mode_r      <= mode_nxt;
			cmd_r       <= cmd_nxt;
		end
	end

	// ==========================================================================
	// Stamp storage, pointers and overflow counters
	stamp_s [CHANNELS-1:0][DEPTH-1:0]  mem_r;
	stamp_s [CHANNELS-1:0][DEPTH-1:0]  mem_nxt;
	logic [CHANNELS-1:0][PTR_W-1:0]    wr_r;
	logic [CHANNELS-1:0][PTR_W-1:0]    wr_nxt;
	logic [CHANNELS-1:0][CNT_W-1:0]    cnt_r;
	logic [CHANNELS-1:0][CNT_W-1:0]    cnt_nxt;
	logic [CHANNELS-1:0][OVF_W-1:0]    ovf_r;
	logic [CHANNELS-1:0][OVF_W-1:0]    ovf_nxt;
	logic                              capture_en;

	// Events that land while the host holds the buffers are dropped, not
	// queued; this keeps every read consistent at the cost of lost stamps.
	assign capture_en = armed_r && (state_r == ST_IDLE) && !cmd_take;

	always_comb
	begin
		mem_nxt = mem_r;
		wr_nxt  = wr_r;
		cnt_nxt = cnt_r;
		ovf_nxt = ovf_r;
		for (int c = 0; c < CHANNELS; c++)
		begin
			if (state_r == ST_ACCESS && (cmd_r.op == CMD_PRESET ||
				(cmd_r.op == CMD_CLEAR_CHAN && chan_ok(cmd_r.tag_channel_select) &&
				chan_idx(cmd_r.tag_channel_select) == 2'(c))))
			begin
				wr_nxt[c]  = '0;
				cnt_nxt[c] = CNT_ZERO;
				ovf_nxt[c] = OVF_ZERO;
			end
			else if (capture_en && hit[c])
			begin
				if (cnt_r[c] != CNT_FULL)
				begin
					mem_nxt[c][wr_r[c]] = time_now_i;
					wr_nxt[c]           = wr_r[c] + 1'b1;
					cnt_nxt[c]          = cnt_r[c] + 1'b1;
				end
				else
				begin
					if (mode_r == RETAIN_NEWEST)
					begin
						mem_nxt[c][wr_r[c]] = time_now_i;
						wr_nxt[c]           = wr_r[c] + 1'b1;
					end
					if (ovf_r[c] != OVF_MAX)
						ovf_nxt[c] = ovf_r[c] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_r  <= '0;
			cnt_r <= '0;
			ovf_r <= '0;
		end
		else
		begin
			wr_r  <= wr_nxt;
			cnt_r <= cnt_nxt;
			ovf_r <= ovf_nxt;
		end
		mem_r <= mem_nxt;
	end

	// ==========================================================================
	// Responses
	logic       rsp_valid_r;
	logic       rsp_valid_nxt;
	rsp_s       rsp_r;
	rsp_s       rsp_nxt;
	logic [1:0] sel;
	logic       sel_ok;
	logic [PTR_W-1:0] base;
	logic [PTR_W-1:0] addr;
	logic       entry_ok;

	assign sel    = chan_idx(cmd_r.tag_channel_select);
	assign sel_ok = chan_ok(cmd_r.tag_channel_select);
	// Once a buffer is full the write pointer marks its oldest stamp.
	assign base   = (cnt_r[sel] == CNT_FULL) ? wr_r[sel] : '0;
	assign addr   = base + PTR_W'(cmd_r.entry - ENTRY_MIN);
	assign entry_ok = (cmd_r.entry >= ENTRY_MIN) && (cmd_r.entry <= cnt_r[sel]);

	always_comb
	begin
		rsp_valid_nxt = 1'b0;
		rsp_nxt       = rsp_r;
		if (state_r == ST_ACCESS)
		begin
			rsp_valid_nxt = 1'b1;
			rsp_nxt       = '0;
			rsp_nxt.mode  = mode_r;
			case (cmd_r.op)
				CMD_READ_ENTRY:
				begin
					if (sel_ok && entry_ok)
						rsp_nxt.stamp = mem_r[sel][addr];
					else
						rsp_nxt.err = 1'b1;
				end
				CMD_READ_COUNT:
				begin
					if (sel_ok)
						rsp_nxt.count = cnt_r[sel];
					else
						rsp_nxt.err = 1'b1;
				end
				CMD_READ_OVF_ALL:
					rsp_nxt.ovf = ovf_r;
				CMD_READ_OVF_ONE:
				begin
					if (sel_ok)
						rsp_nxt.ovf[0] = ovf_r[sel];
					else
						rsp_nxt.err = 1'b1;
				end
				CMD_SET_MODE:
					rsp_nxt.mode = cmd_r.mode;
				CMD_GET_MODE:
					rsp_nxt.mode = mode_r;
				CMD_CLEAR_CHAN:
					rsp_nxt.err = !sel_ok;
				CMD_PRESET:
					rsp_nxt.mode = RETAIN_OLDEST;
				default:
					rsp_nxt.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			rsp_valid_r <= 1'b0;
			rsp_r       <= '0;
		end
		else
		begin
			rsp_valid_r <= rsp_valid_nxt;
			rsp_r       <= rsp_nxt;
		end
	end

	// ==========================================================================
	// Outputs
	logic ready_r;
	logic ready_nxt;

	always_comb
	begin
		ready_nxt = (state_nxt == ST_IDLE);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			ready_r <= 1'b0;
		else
			ready_r <= ready_nxt;
	end

	assign cmd_ready_o = ready_r;
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_o       = rsp_r;
	assign mode_o      = mode_r;
	assign armed_o     = armed_r;

endmodule

`default_nettype wire

/* bench/tag_buffer_props.sv */
// Checker for the tag store command port, attached to the top module by bind.
// Assumes the command, answer and mode timing given for the design's ports.
`timescale 1ns/1ps
`default_nettype none

module tag_buffer_props
	import tag_buffer_pkg::*;
(
	input  wire logic    core_clk_i,
	input  wire logic    rst_i,
	input  wire logic    powerup_done_i,
	input  wire logic    ref_locked_i,
	input  wire logic    cmd_valid_i,
	input  wire cmd_s    cmd_i,
	input  wire logic    cmd_ready_o,
	input  wire logic    rsp_valid_o,
	input  wire rsp_s    rsp_o,
	input  wire retain_e mode_o,
	input  wire logic    armed_o
);
	// ==========
	// Sequences
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_op(cmd_e o);
		cmd_valid_i && cmd_ready_o && cmd_i.op == o;
	endsequence
	sequence s_take;
		cmd_valid_i && cmd_ready_o;
	endsequence
	sequence s_answer;
		!rsp_valid_o ##1 rsp_valid_o ##1 !rsp_valid_o;
	endsequence

	// ==========
	// Properties
	property p_answer;
		s_take |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("answer not two edges after take");
	property p_busy;
		s_take |=> !cmd_ready_o [*2] ##1 cmd_ready_o;
	endproperty
	a_busy: assert property (p_busy) else $error("ready wrong during access");
	property p_count;
		rsp_valid_o |-> rsp_o.count <= CNT_FULL;
	endproperty
	a_count: assert property (p_count) else $error("count above full");
	property p_arm;
		$rose(armed_o) |-> $past(powerup_done_i) && $past(ref_locked_i);
	endproperty
	a_arm: assert property (p_arm) else $error("armed without power-up and lock");
	property p_preset;
		s_op(CMD_PRESET) |-> ##2 mode_o == RETAIN_OLDEST;
	endproperty
	a_preset: assert property (p_preset) else $error("preset left mode");
	property p_getmode;
		s_op(CMD_GET_MODE) |-> ##2 rsp_valid_o && rsp_o.mode == mode_o;
	endproperty
	a_getmode: assert property (p_getmode) else $error("mode query wrong");
	property p_setmode;
		s_op(CMD_SET_MODE) |-> ##2 mode_o == $past(cmd_i.mode, 2);
	endproperty
	a_setmode: assert property (p_setmode) else $error("mode not set");
	property p_one;
		s_op(CMD_READ_OVF_ONE) |-> ##2 rsp_o.ovf[1] == OVF_ZERO && rsp_o.ovf[2] == OVF_ZERO;
	endproperty
	a_one: assert property (p_one) else $error("other counters shown");
	property p_badch;
		s_take ##0 (cmd_i.tag_channel_select == 2'h0 && cmd_i.op inside {CMD_READ_ENTRY,
			CMD_READ_COUNT, CMD_READ_OVF_ONE, CMD_CLEAR_CHAN}) |-> ##2 rsp_o.err;
	endproperty
	a_badch: assert property (p_badch) else $error("channel zero accepted");
endmodule

bind event_time_tag_buffer tag_buffer_props tag_buffer_props_i (.core_clk_i, .rst_i,
	.powerup_done_i, .ref_locked_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .rsp_valid_o,
	.rsp_o, .mode_o, .armed_o);

`default_nettype wire

/* bench/event_source.sv */
// Model of the three event inputs and the time source behind them.
// Assumes calls from the bench just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module event_source
	import tag_buffer_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic [CHANNELS-1:0] fall_i,
	output logic      [CHANNELS-1:0] ev_o,
	output stamp_s                   time_o
);
	logic [CHANNELS-1:0] act = '0;

	// Idle level follows the polarity, so each pulse gives one counted edge.
	assign ev_o = fall_i ^ act;
	initial time_o = '0;

	// Time holds for four cycles, so the stamp is the pulse number.
	task automatic burst(input int ch, input int n);
		for (int k = 1; k <= n; k++)
		begin
			@(posedge clk_i);
			#1 time_o.nano = k[9:0];
			act[ch] = 1'b1;
			@(posedge clk_i);
			#1 act[ch] = 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
		#1;
	endtask
endmodule

`default_nettype wire

/* bench/tb.sv */
// Bench for the tag store: arming, both retention modes, overflow and preset.
// Assumes the event_source model and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module tb;
	import tag_buffer_pkg::*;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                pwr = 1'b0;
	logic                lock = 1'b1;
	logic                cv = 1'b0;
	retain_e             nv = RETAIN_NEWEST;
	cmd_s                cm = '0;
	logic [CHANNELS-1:0] ev;
	stamp_s              tnow;
	logic                rdy, rv, armed;
	rsp_s                rsp, rs;
	retain_e             md;
	int                  num_errors = 0;
	int                  checked = 0;

	always #10 clk = ~clk;

	event_source event_source_i (.clk_i(clk),
		.fall_i(3'b010), .ev_o(ev), .time_o(tnow));
	event_time_tag_buffer event_time_tag_buffer_i (.core_clk_i(clk), .rst_i(rst),
		.event_i(ev), .edge_fall_i(3'b010), .powerup_done_i(pwr), .ref_locked_i(lock),
		.time_now_i(tnow), .nv_mode_i(nv), .cmd_valid_i(cv), .cmd_i(cm),
		.cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_o(rsp), .mode_o(md), .armed_o(armed));

	// ==========
	// Tasks
	task automatic summarize();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmd(input cmd_e op, input logic [1:0] ch, input logic [8:0] e,
		input retain_e m);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 9)
		begin
			@(posedge clk);
			#1 n++;
		end
		cv = 1'b1;
		cm = '{op, ch, e, m};
		@(posedge clk);
		#1 cv = 1'b0;
		n = 0;
		while (rv !== 1'b1 && n < 9)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (rv !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t no answer to command", $time);
			summarize();
		end
		rs = rsp;
		@(posedge clk);
		#1;
	endtask

	task automatic t_arm();
		int n;
		n = 0;
		event_source_i.burst(0, 3);
		cmd(CMD_READ_COUNT, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, CNT_ZERO)
		pwr = 1'b1;
		while (armed !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(armed, 1'b1)
		if (armed !== 1'b1)
			summarize();
		lock = 1'b0;
		event_source_i.burst(2, 2);
		cmd(CMD_READ_COUNT, 2'h3, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, 9'h002)
		$display("arm test done");
	endtask

	task automatic t_oldest();
		cmd(CMD_SET_MODE, 2'h1, 9'h000, RETAIN_OLDEST);
		event_source_i.burst(0, 258);
		cmd(CMD_READ_COUNT, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, CNT_FULL)
		cmd(CMD_READ_ENTRY, 2'h1, ENTRY_MIN, RETAIN_OLDEST);
		`CHK(rs.stamp.nano, 10'h001)
		cmd(CMD_READ_ENTRY, 2'h1, 9'h100, RETAIN_OLDEST);
		`CHK(rs.stamp.nano, 10'h100)
		cmd(CMD_READ_ENTRY, 2'h1, 9'h101, RETAIN_OLDEST);
		`CHK(rs.err, 1'b1)
		cmd(CMD_READ_COUNT, 2'h0, 9'h000, RETAIN_OLDEST);
		`CHK(rs.err, 1'b1)
		cmd(CMD_READ_OVF_ALL, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.ovf, {OVF_ZERO, OVF_ZERO, 32'h00000002})
		$display("keep-oldest test done");
	endtask

	task automatic t_newest();
		cmd(CMD_SET_MODE, 2'h2, 9'h000, RETAIN_NEWEST);
		cmd(CMD_GET_MODE, 2'h2, 9'h000, RETAIN_OLDEST);
		`CHK(rs.mode, RETAIN_NEWEST)
		event_source_i.burst(1, 259);
		cmd(CMD_READ_ENTRY, 2'h2, ENTRY_MIN, RETAIN_OLDEST);
		`CHK(rs.stamp.nano, 10'h004)
		cmd(CMD_READ_ENTRY, 2'h2, 9'h100, RETAIN_OLDEST);
		`CHK(rs.stamp.nano, 10'h103)
		cmd(CMD_READ_OVF_ONE, 2'h2, 9'h000, RETAIN_OLDEST);
		`CHK(rs.ovf[0], 32'h00000003)
		$display("keep-newest test done");
	endtask

	task automatic t_preset();
		cmd(CMD_CLEAR_CHAN, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.err, 1'b0)
		cmd(CMD_READ_COUNT, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, CNT_ZERO)
		cmd(CMD_READ_OVF_ONE, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.ovf[0], OVF_ZERO)
		cmd(CMD_READ_COUNT, 2'h3, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, 9'h002)
		cmd(CMD_PRESET, 2'h1, 9'h000, RETAIN_NEWEST);
		`CHK(md, RETAIN_OLDEST)
		cmd(CMD_READ_COUNT, 2'h2, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, CNT_ZERO)
		cmd(CMD_READ_COUNT, 2'h3, 9'h000, RETAIN_OLDEST);
		`CHK(rs.count, CNT_ZERO)
		cmd(CMD_READ_OVF_ALL, 2'h1, 9'h000, RETAIN_OLDEST);
		`CHK(rs.ovf, {3{OVF_ZERO}})
		$display("preset test done");
	endtask

	// ==========
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK(md, RETAIN_NEWEST)
		t_arm();
		t_oldest();
		t_newest();
		t_preset();
		summarize();
	end
endmodule

`default_nettype wire
